// ### design/mscfg_pkg.sv
// package for the startup sequence configuration register block
// assumes an axi4-lite master with 32-bit data and byte addressing
package mscfg_pkg;

    // register map
    localparam logic [7:0] MSCFG_ADDR_STARTUP = 8'h84;
    localparam logic [31:0] MSCFG_RESET_STARTUP = 32'h0000_0000;
    localparam logic [31:0] MSCFG_RESERVED_MASK = 32'h8000_0000;

    // field positions
    localparam int MSCFG_POS_METHOD = 29;
    localparam int MSCFG_POS_RAMP = 25;
    localparam int MSCFG_POS_ALIGN_TIME = 21;
    localparam int MSCFG_POS_CURRENT_CAP = 17;
    localparam int MSCFG_POS_PROBE_RATE = 14;
    localparam int MSCFG_POS_PROBE_THR = 9;
    localparam int MSCFG_POS_RELEASE = 8;
    localparam int MSCFG_POS_LEAD_ANGLE = 6;
    localparam int MSCFG_POS_REPEAT = 4;
    localparam int MSCFG_POS_OL_SOURCE = 3;
    localparam int MSCFG_POS_IQ_RAMP = 2;
    localparam int MSCFG_POS_BRAKE = 1;
    localparam int MSCFG_POS_REVERSE = 0;

    // axi response codes
    localparam logic [1:0] MSCFG_RESP_OKAY = 2'h0;
    localparam logic [1:0] MSCFG_RESP_SLVERR = 2'h2;

    // start-up method codes
    typedef enum logic [1:0] {
        MSCFG_START_ALIGN = 2'h0,
        MSCFG_START_DOUBLE_ALIGN = 2'h1,
        MSCFG_START_POSITION_PROBE = 2'h2,
        MSCFG_START_SLOW_CYCLE = 2'h3
    } mscfg_method_e;

    // decoded fields, as handed to the start-up controller
    typedef struct packed {
        logic reserved_bit;
        mscfg_method_e startup_method_sel;
        logic [3:0] ramp_rate_sel;
        logic [3:0] align_time_sel;
        logic [3:0] startup_current_cap_sel;
        logic [2:0] position_probe_rate_sel;
        logic [4:0] position_probe_threshold;
        logic position_probe_release_sel;
        logic [1:0] position_probe_lead_angle;
        logic [1:0] position_probe_repeat_sel;
        logic openloop_limit_source;
        logic torque_current_rampdown_en;
        logic active_brake_en;
        logic reverse_profile_sel;
    } mscfg_fields_s;

endpackage

// ### design/mscfg_startup_reg.sv
// startup sequence configuration register with an axi4-lite slave
// assumes one clock, synchronous active-low reset, and a clock enable
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps

module mscfg_startup_reg
    import mscfg_pkg::*;
(
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // axi4-lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // configuration to the start-up controller
    output mscfg_fields_s startup_cfg
);

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // word-aligned match; low two address bits are ignored
    function automatic logic hits_reg(input logic [7:0] addr);
        hits_reg = (addr[7:2] == MSCFG_ADDR_STARTUP[7:2]);
    endfunction

    // merge write data under byte strobes
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_val, input logic [31:0] new_val,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        merge_bytes = res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // write channel state

    logic [31:0] startup_sequence_config;
    logic [31:0] next_startup_sequence_config;
    logic aw_held;
    logic next_aw_held;
    logic [7:0] aw_addr;
    logic [7:0] next_aw_addr;
    logic w_held;
    logic next_w_held;
    logic [31:0] w_data;
    logic [31:0] next_w_data;
    logic [3:0] w_strb;
    logic [3:0] next_w_strb;
    logic bvalid;
    logic next_bvalid;
    logic [1:0] bresp;
    logic [1:0] next_bresp;

    // address and data are held until both are in; no new ones while a response waits
    // handshakes are masked while frozen, so the master never sees a take that did not happen
    assign s_axi_awready = clk_en && !aw_held && !bvalid;
    assign s_axi_wready = clk_en && !w_held && !bvalid;
    assign s_axi_bvalid = clk_en && bvalid;
    assign s_axi_bresp = bresp;

    // next-state for the write path and the register itself
    always_comb begin
        logic have_aw;
        logic have_w;
        logic [7:0] use_addr;
        logic [31:0] use_data;
        logic [3:0] use_strb;
        have_aw = aw_held || (s_axi_awvalid && s_axi_awready);
        have_w = w_held || (s_axi_wvalid && s_axi_wready);
        use_addr = aw_held ? aw_addr : s_axi_awaddr;
        use_data = w_held ? w_data : s_axi_wdata;
        use_strb = w_held ? w_strb : s_axi_wstrb;
        next_startup_sequence_config = startup_sequence_config;
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (have_aw && have_w && !bvalid) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            if (hits_reg(use_addr)) begin
                // reserved bit 31 stores as well, so reads give back what was written
                next_startup_sequence_config = merge_bytes(startup_sequence_config, use_data, use_strb);
                next_bresp = MSCFG_RESP_OKAY;
            end else begin
                next_bresp = MSCFG_RESP_SLVERR; // unmapped, write dropped
            end
        end
    end

    // write path registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            startup_sequence_config <= MSCFG_RESET_STARTUP;
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= MSCFG_RESP_OKAY;
        end else if (clk_en) begin
            startup_sequence_config <= next_startup_sequence_config;
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read channel state

    logic rvalid;
    logic next_rvalid;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic [1:0] rresp;
    logic [1:0] next_rresp;

    // one read in flight; arready drops while the answer waits
    assign s_axi_arready = clk_en && !rvalid;
    assign s_axi_rvalid = clk_en && rvalid; // hidden while frozen, else one answer could be taken twice
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;

    // read next-state; reading touches nothing but the read channel
    always_comb begin
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            if (hits_reg(s_axi_araddr)) begin
                next_rdata = startup_sequence_config;
                next_rresp = MSCFG_RESP_OKAY;
            end else begin
                next_rdata = 32'h0000_0000;
                next_rresp = MSCFG_RESP_SLVERR;
            end
        end
    end

    // read path registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= MSCFG_RESP_OKAY;
        end else if (clk_en) begin
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // field decode toward the start-up controller

    // plain slices; reserved codes pass through untouched, the consumer must guard them
    always_comb begin
        startup_cfg.reserved_bit = startup_sequence_config[31];
        startup_cfg.startup_method_sel = mscfg_method_e'(startup_sequence_config[MSCFG_POS_METHOD +: 2]);
        startup_cfg.ramp_rate_sel = startup_sequence_config[MSCFG_POS_RAMP +: 4];
        startup_cfg.align_time_sel = startup_sequence_config[MSCFG_POS_ALIGN_TIME +: 4];
        startup_cfg.startup_current_cap_sel = startup_sequence_config[MSCFG_POS_CURRENT_CAP +: 4];
        startup_cfg.position_probe_rate_sel = startup_sequence_config[MSCFG_POS_PROBE_RATE +: 3];
        startup_cfg.position_probe_threshold = startup_sequence_config[MSCFG_POS_PROBE_THR +: 5];
        startup_cfg.position_probe_release_sel = startup_sequence_config[MSCFG_POS_RELEASE];
        startup_cfg.position_probe_lead_angle = startup_sequence_config[MSCFG_POS_LEAD_ANGLE +: 2];
        startup_cfg.position_probe_repeat_sel = startup_sequence_config[MSCFG_POS_REPEAT +: 2];
        startup_cfg.openloop_limit_source = startup_sequence_config[MSCFG_POS_OL_SOURCE];
        startup_cfg.torque_current_rampdown_en = startup_sequence_config[MSCFG_POS_IQ_RAMP];
        startup_cfg.active_brake_en = startup_sequence_config[MSCFG_POS_BRAKE];
        startup_cfg.reverse_profile_sel = startup_sequence_config[MSCFG_POS_REVERSE];
    end

endmodule

// ### tb/mscfg_startup_monitor.sv
// checker for the startup register block
// assumes one clock and binding onto mscfg_startup_reg
`timescale 1ns/10ps

module mscfg_startup_monitor
    import mscfg_pkg::*;
(
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // write side
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read side
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // decoded fields
    input mscfg_fields_s startup_cfg
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // handshakes only count while the clock enable runs
    sequence wr_hit;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clk_en;
    endsequence
    sequence rd_hit;
        s_axi_arvalid && s_axi_arready && clk_en;
    endsequence
    a_reset_zero: assert property ($rose(aresetn) |-> startup_cfg == '0) else $error("cfg not clear");
    a_write_commit: assert property (wr_hit ##0 (s_axi_awaddr[7:2] == 6'h21 && s_axi_wstrb == 4'hf) |=>
        (s_axi_bvalid || !clk_en) && s_axi_bresp == MSCFG_RESP_OKAY &&
        startup_cfg == $past(s_axi_wdata)) else $error("write lost");
    a_field_map: assert property (wr_hit ##0 (s_axi_awaddr[7:2] == 6'h21 && s_axi_wstrb[3]) |=>
        startup_cfg.startup_method_sel == $past(s_axi_wdata[30:29])) else $error("method field misplaced");
    a_unmapped_err: assert property (wr_hit ##0 (s_axi_awaddr[7:2] != 6'h21) |=>
        s_axi_bresp == MSCFG_RESP_SLVERR && $stable(startup_cfg)) else $error("unmapped write accepted");
    a_read_value: assert property (rd_hit ##0 (s_axi_araddr[7:2] == 6'h21) |=>
        (s_axi_rvalid || !clk_en) && s_axi_rresp == MSCFG_RESP_OKAY &&
        s_axi_rdata == $past(startup_cfg)) else $error("bad read");
    // a frozen enable masks the valids, so holds are only owed while the enable runs
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        (s_axi_rvalid || !clk_en) && $stable(s_axi_rdata)) else $error("read answer dropped");
    a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        (s_axi_bvalid || !clk_en) && $stable(s_axi_bresp)) else $error("write answer dropped");
    a_quiet_cfg: assert property ($changed(startup_cfg) |-> s_axi_bvalid || !clk_en)
        else $error("cfg changed by itself");
endmodule

bind mscfg_startup_reg mscfg_startup_monitor chk (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .startup_cfg(startup_cfg)
);

// ### tb/tb_mscfg_startup_reg.sv
// testbench for the startup register block
// assumes the checker is bound by its own file
`timescale 1ns/10ps

module tb_mscfg_startup_reg
    import mscfg_pkg::*;
;
    logic aclk, aresetn, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d, sh;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    mscfg_fields_s startup_cfg;
    logic [33:0] exp_q[$];
    int mismatches, samples_checked, seed, n;

    mscfg_startup_reg dut (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_en(clk_en),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .startup_cfg(startup_cfg)
    );

    // 40 mhz clock
    initial begin
        aclk = 0;
        forever #12.5 aclk = ~aclk;
    end

    task automatic finish_test;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            mismatches++;
        end
    endtask

    // a hung handshake counts as a mismatch and ends the run
    task automatic tmo;
        if (n == 60) begin
            mismatches++;
            finish_test;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [3:0] s, input logic [1:0] r);
        exp_q.push_back({r, 32'h0});
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, dat, s};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        for (n = 0; n < 60; n++) begin
            @(posedge aclk);
            if (s_axi_bvalid) break;
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end
        s_axi_bready <= 0;
        tmo;
    endtask

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        for (n = 0; n < 60; n++) begin
            @(posedge aclk);
            if (s_axi_rvalid) break;
            if (s_axi_arready) s_axi_arvalid <= 0;
        end
        s_axi_rready <= 0;
        tmo;
    endtask

    // answers are matched against the oldest note
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready)
            chk("bresp", exp_q.pop_front(), {s_axi_bresp, 32'h0});
        if (s_axi_rvalid && s_axi_rready)
            chk("rdata", exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
    end

    ////////////////////////////////////////////////
    initial begin
        seed = 76;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= '0;
        clk_en <= 1;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        chk("cfg", 34'h0, 34'(startup_cfg));
        rd(8'h84, {MSCFG_RESP_OKAY, 32'h0});
        $display("reset test done");
        // every method and cap code, reserved caps too, other bits random
        for (int i = 0; i < 16; i++) begin
            d = $random(seed);
            d[30:29] = i[1:0];
            d[20:17] = i[3:0];
            wr({6'h21, i[1:0]}, d, 4'hf, MSCFG_RESP_OKAY);
            rd(8'h84, {MSCFG_RESP_OKAY, d});
            chk("method", 34'(i[1:0]), 34'(startup_cfg.startup_method_sel));
            chk("cap", 34'(i[3:0]), 34'(startup_cfg.startup_current_cap_sel));
            chk("fields", 34'(d), 34'(startup_cfg));
        end
        $display("field test done");
        // only lanes 0 and 2 may change
        sh = $random(seed);
        wr(8'h84, sh, 4'b0101, MSCFG_RESP_OKAY);
        sh = {d[31:24], sh[23:16], d[15:8], sh[7:0]};
        rd(8'h84, {MSCFG_RESP_OKAY, sh});
        wr(8'h88, ~sh, 4'hf, MSCFG_RESP_SLVERR);
        rd(8'h80, {MSCFG_RESP_SLVERR, 32'h0});
        rd(8'h84, {MSCFG_RESP_OKAY, sh});
        $display("lane and map test done");
        // a frozen enable must hold the write back until it runs
        clk_en <= 0;
        fork
            wr(8'h84, 32'h8000_0001, 4'hf, MSCFG_RESP_OKAY);
            begin
                repeat (4) @(posedge aclk);
                clk_en <= 1;
            end
        join
        rd(8'h84, {MSCFG_RESP_OKAY, 32'h8000_0001});
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        chk("cfg", 34'h0, 34'(startup_cfg));
        rd(8'h84, {MSCFG_RESP_OKAY, 32'h0});
        $display("enable and reset test done");
        finish_test;
    end
endmodule
